// file: hdl/mia_pkg.sv
// Package for the MAC interrupt aggregator: register map, fields, resets, types
package mia_pkg;
  localparam int NUM_CH = 8;
  localparam int PTR_W = 32;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STAT_W = 32;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_TX_RAW = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TX_MASKED = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TX_EN_SET = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TX_EN_CLR = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_RX_RAW = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_RX_MASKED = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_RX_EN_SET = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_RX_EN_CLR = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_MISC_RAW = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_MISC_MASKED = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_MISC_EN_SET = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_MISC_EN_CLR = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_LINK_RAW = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_LINK_MASKED = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_LINK_EN = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_USER_RAW = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_USER_MASKED = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_USER_EN_SET = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_USER_EN_CLR = 8'h4C;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h50;
  localparam logic [ADDR_W-1:0] OFS_TX_CP_BASE = 8'h80;
  localparam logic [ADDR_W-1:0] OFS_RX_CP_BASE = 8'hA0;
  localparam logic [ADDR_W-1:0] OFS_CP_MASK = 8'hE0;
  // Field positions in the misc and control registers
  localparam int MISC_STATS_BIT = 0;
  localparam int MISC_HOST_BIT = 1;
  localparam int CTRL_EN_BIT = 0;
  // Reset values
  localparam logic [NUM_CH-1:0] RST_CH_EN = 8'h00;
  localparam logic [PTR_W-1:0] RST_PTR = 32'h0000_0000;
  localparam logic [1:0] RST_PAIR = 2'h0;
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

  // Descriptor error causes
  typedef struct packed {
    logic sop_err;
    logic sop_unowned;
    logic zero_next_no_eop;
    logic zero_buf_ptr;
    logic zero_buf_len;
    logic pkt_len_err;
  } mia_tx_err_t;

  typedef struct packed {
    logic unowned;
    logic zero_buf_ptr;
  } mia_rx_err_t;

  // Completion pointer write from the DMA side
  typedef struct packed {
    logic valid;
    logic [2:0] ch;
    logic [PTR_W-1:0] addr;
  } mia_cp_wr_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mia_bus_req_t;
endpackage

// file: hdl/mia_top.sv
// MAC and management interrupt aggregator with register port
`timescale 1ns/1ps
// Behaviour
// - Eight level transmit completion interrupts, held until host acknowledge clears.
// - Transmit enable set by write-one-set, cleared by write-one-clear register.
// - Raw and masked transmit status readable, one bit per channel.
// - Device pointer store raises channel interrupt whatever value stored.
// - Host pointer write compared, not stored; equal clears, unequal keeps.
// - Transmit pointer read returns device-stored descriptor address.
// - Eight level receive completion interrupts held until acknowledged.
// - Receive enables by set/clear registers; raw and masked status readable.
// - Device receive pointer store raises channel interrupt regardless of value.
// - Host receive pointer write compared only; clears on match.
// - Receive pointer read returns device-stored address.
// - Statistics interrupt when any counter at or above threshold, if enabled.
// - Statistics interrupt follows counter top bits; host decrements to clear.
// - Descriptor error interrupt sticky until reset of unit.
// - Descriptor error enable by set/clear registers; raw and masked readable.
// - Six transmit descriptor faults flag the host error.
// - Receive unowned or zero-pointer descriptor flags the host error.
// - Link change of monitored PHY flags interrupt when link enable set.
// - Link events in raw bits 0 and 1; masked write-one clears.
// - User access go falling edge flags interrupt in raw bits 0, 1.
// - Enabled user event sets masked bit; write-one clears it.
// - Re-enabling combined enable gives new rising edge if source active.
// - Combined output low while enable zero; high if any source active.
module mia_top
(
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  // Register port
  input wire mia_pkg::mia_bus_req_t bus_i,
  output logic [mia_pkg::DATA_W-1:0] rdata_o,
  // DMA completion pointer stores
  input wire mia_pkg::mia_cp_wr_t tx_cp_wr_i,
  input wire mia_pkg::mia_cp_wr_t rx_cp_wr_i,
  // Descriptor faults and statistics top bits
  input wire mia_pkg::mia_tx_err_t tx_err_i,
  input wire mia_pkg::mia_rx_err_t rx_err_i,
  input wire logic [mia_pkg::STAT_W-1:0] stats_msb_i,
  // Management unit events
  input wire logic [1:0] phy_link_i,
  input wire logic [1:0] user_go_i,
  // Interrupt outputs
  output logic [mia_pkg::NUM_CH-1:0] tx_done_irq_o,
  output logic [mia_pkg::NUM_CH-1:0] rx_done_irq_o,
  output logic stats_overflow_irq_o,
  output logic descriptor_error_irq_o,
  output logic link_change_irq_o,
  output logic user_access_done_irq_o,
  output logic combined_cpu_irq_o
);
  localparam int N = mia_pkg::NUM_CH;
  localparam int W = mia_pkg::PTR_W;

  // Reset release synchroniser
  logic rst_meta_r, rst_n_r;
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  wire logic wr = bus_i.wr;
  wire logic [mia_pkg::ADDR_W-1:0] adr = bus_i.addr;
  wire logic [mia_pkg::DATA_W-1:0] wd = bus_i.wdata;
  wire logic cp_sel = (adr & mia_pkg::OFS_CP_MASK) == mia_pkg::OFS_TX_CP_BASE;
  wire logic rp_sel = (adr & mia_pkg::OFS_CP_MASK) == mia_pkg::OFS_RX_CP_BASE;
  wire logic [2:0] cp_idx = adr[4:2];

  // Completion pointer state and pending bits
  logic [W-1:0] tx_cp_r [N];
  logic [W-1:0] rx_cp_r [N];
  logic [W-1:0] tx_cp_nxt [N];
  logic [W-1:0] rx_cp_nxt [N];
  logic [N-1:0] tx_raw_r, tx_raw_nxt, rx_raw_r, rx_raw_nxt;
  logic [N-1:0] tx_en_r, tx_en_nxt, rx_en_r, rx_en_nxt;

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_ch
      always_comb
      begin
        tx_cp_nxt[g] = tx_cp_r[g];
        tx_raw_nxt[g] = tx_raw_r[g];
        rx_cp_nxt[g] = rx_cp_r[g];
        rx_raw_nxt[g] = rx_raw_r[g];
        // Host acknowledge compares only; DMA store wins over same-cycle clear
        if (wr && cp_sel && cp_idx == 3'(g) && wd == tx_cp_r[g])
          tx_raw_nxt[g] = 1'b0;
        if (tx_cp_wr_i.valid && tx_cp_wr_i.ch == 3'(g))
        begin
          tx_cp_nxt[g] = tx_cp_wr_i.addr;
          tx_raw_nxt[g] = 1'b1;
        end
        if (wr && rp_sel && cp_idx == 3'(g) && wd == rx_cp_r[g])
          rx_raw_nxt[g] = 1'b0;
        if (rx_cp_wr_i.valid && rx_cp_wr_i.ch == 3'(g))
        begin
          rx_cp_nxt[g] = rx_cp_wr_i.addr;
          rx_raw_nxt[g] = 1'b1;
        end
      end

      always_ff @(posedge ref_clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          tx_cp_r[g] <= mia_pkg::RST_PTR;
          rx_cp_r[g] <= mia_pkg::RST_PTR;
        end
        else if (!rst_n_r)
        begin
          tx_cp_r[g] <= mia_pkg::RST_PTR;
          rx_cp_r[g] <= mia_pkg::RST_PTR;
        end
        else if (clk_en_i)
        begin
          tx_cp_r[g] <= tx_cp_nxt[g];
          rx_cp_r[g] <= rx_cp_nxt[g];
        end
      end
    end
  endgenerate

  // Event synchronisers for pins from the management unit
  logic [1:0] link_m_r, link_s_r, link_d_r, go_m_r, go_s_r, go_d_r;
  logic [1:0] link_raw_r, link_raw_nxt, link_en_r, link_en_nxt;
  logic [1:0] user_raw_r, user_raw_nxt, user_en_r, user_en_nxt;
  logic stats_m_r, stats_r, stats_en_r, stats_en_nxt;
  logic host_raw_r, host_raw_nxt, host_en_r, host_en_nxt;
  logic irq_en_r, irq_en_nxt;

  wire logic [1:0] link_evt = link_s_r ^ link_d_r;
  wire logic [1:0] go_fall = go_d_r & ~go_s_r;
  wire logic tx_fault = |tx_err_i;
  wire logic rx_fault = |rx_err_i;
  wire logic wr_link_m = wr && adr == mia_pkg::OFS_LINK_MASKED;
  wire logic wr_user_m = wr && adr == mia_pkg::OFS_USER_MASKED;

  always_comb
  begin
    tx_en_nxt = tx_en_r;
    rx_en_nxt = rx_en_r;
    stats_en_nxt = stats_en_r;
    host_en_nxt = host_en_r;
    user_en_nxt = user_en_r;
    link_en_nxt = link_en_r;
    irq_en_nxt = irq_en_r;
    if (wr)
    begin
      case (adr)
        mia_pkg::OFS_TX_EN_SET: tx_en_nxt = tx_en_r | wd[N-1:0];
        mia_pkg::OFS_TX_EN_CLR: tx_en_nxt = tx_en_r & ~wd[N-1:0];
        mia_pkg::OFS_RX_EN_SET: rx_en_nxt = rx_en_r | wd[N-1:0];
        mia_pkg::OFS_RX_EN_CLR: rx_en_nxt = rx_en_r & ~wd[N-1:0];
        mia_pkg::OFS_MISC_EN_SET:
        begin
          stats_en_nxt = stats_en_r | wd[mia_pkg::MISC_STATS_BIT];
          host_en_nxt = host_en_r | wd[mia_pkg::MISC_HOST_BIT];
        end
        mia_pkg::OFS_MISC_EN_CLR:
        begin
          stats_en_nxt = stats_en_r & ~wd[mia_pkg::MISC_STATS_BIT];
          host_en_nxt = host_en_r & ~wd[mia_pkg::MISC_HOST_BIT];
        end
        mia_pkg::OFS_LINK_EN: link_en_nxt = wd[1:0];
        mia_pkg::OFS_USER_EN_SET: user_en_nxt = user_en_r | wd[1:0];
        mia_pkg::OFS_USER_EN_CLR: user_en_nxt = user_en_r & ~wd[1:0];
        mia_pkg::OFS_CTRL: irq_en_nxt = wd[mia_pkg::CTRL_EN_BIT];
        default: irq_en_nxt = irq_en_r;
      endcase
    end
    // Sticky until unit reset
    host_raw_nxt = host_raw_r | tx_fault | rx_fault;
    // Event set wins over write-one clear of the masked bit
    link_raw_nxt = (link_raw_r & ~(wr_link_m ? (wd[1:0] & link_en_r) : 2'h0))
                   | (link_evt & link_en_r);
    user_raw_nxt = (user_raw_r & ~(wr_user_m ? (wd[1:0] & user_en_r) : 2'h0))
                   | go_fall;
  end

  // Masked sources and combined line
  logic [N-1:0] tx_msk, rx_msk;
  logic [1:0] link_msk, user_msk;
  logic stats_msk, host_msk, any_src;
  always_comb
  begin
    tx_msk = tx_raw_r & tx_en_r;
    rx_msk = rx_raw_r & rx_en_r;
    stats_msk = stats_r & stats_en_r;
    host_msk = host_raw_r & host_en_r;
    link_msk = link_raw_r & link_en_r;
    user_msk = user_raw_r & user_en_r;
    any_src = |{tx_msk, rx_msk, stats_msk, host_msk, link_msk, user_msk};
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tx_raw_r <= mia_pkg::RST_CH_EN;
      rx_raw_r <= mia_pkg::RST_CH_EN;
      tx_en_r <= mia_pkg::RST_CH_EN;
      rx_en_r <= mia_pkg::RST_CH_EN;
      {link_m_r, link_s_r, link_d_r} <= {3{mia_pkg::RST_PAIR}};
      {go_m_r, go_s_r, go_d_r} <= {3{mia_pkg::RST_PAIR}};
      link_raw_r <= mia_pkg::RST_PAIR;
      link_en_r <= mia_pkg::RST_PAIR;
      user_raw_r <= mia_pkg::RST_PAIR;
      user_en_r <= mia_pkg::RST_PAIR;
      {stats_m_r, stats_r, stats_en_r, host_raw_r, host_en_r, irq_en_r} <= 6'h00;
    end
    else if (!rst_n_r)
    begin
      tx_raw_r <= mia_pkg::RST_CH_EN;
      rx_raw_r <= mia_pkg::RST_CH_EN;
      tx_en_r <= mia_pkg::RST_CH_EN;
      rx_en_r <= mia_pkg::RST_CH_EN;
      {link_m_r, link_s_r, link_d_r} <= {3{mia_pkg::RST_PAIR}};
      {go_m_r, go_s_r, go_d_r} <= {3{mia_pkg::RST_PAIR}};
      link_raw_r <= mia_pkg::RST_PAIR;
      link_en_r <= mia_pkg::RST_PAIR;
      user_raw_r <= mia_pkg::RST_PAIR;
      user_en_r <= mia_pkg::RST_PAIR;
      {stats_m_r, stats_r, stats_en_r, host_raw_r, host_en_r, irq_en_r} <= 6'h00;
    end
    else if (clk_en_i)
    begin
      tx_raw_r <= tx_raw_nxt;
      rx_raw_r <= rx_raw_nxt;
      tx_en_r <= tx_en_nxt;
      rx_en_r <= rx_en_nxt;
      link_m_r <= phy_link_i;
      link_s_r <= link_m_r;
      link_d_r <= link_s_r;
      go_m_r <= user_go_i;
      go_s_r <= go_m_r;
      go_d_r <= go_s_r;
      link_raw_r <= link_raw_nxt;
      link_en_r <= link_en_nxt;
      user_raw_r <= user_raw_nxt;
      user_en_r <= user_en_nxt;
      stats_m_r <= |stats_msb_i;
      stats_r <= stats_m_r;
      stats_en_r <= stats_en_nxt;
      host_raw_r <= host_raw_nxt;
      host_en_r <= host_en_nxt;
      irq_en_r <= irq_en_nxt;
    end
  end

  // Read mux and registered outputs
  logic [mia_pkg::DATA_W-1:0] rd_nxt;
  logic [mia_pkg::DATA_W-1:0] rdata_r;
  logic [N-1:0] tx_irq_r, rx_irq_r;
  logic stats_irq_r, host_irq_r, link_irq_r, user_irq_r, cpu_irq_r;
  always_comb
  begin
    rd_nxt = mia_pkg::RD_ZERO;
    if (bus_i.rd)
    begin
      if (cp_sel)
        rd_nxt = tx_cp_r[cp_idx];
      else if (rp_sel)
        rd_nxt = rx_cp_r[cp_idx];
      else
      begin
        case (adr)
          mia_pkg::OFS_TX_RAW: rd_nxt[N-1:0] = tx_raw_r;
          mia_pkg::OFS_TX_MASKED: rd_nxt[N-1:0] = tx_msk;
          mia_pkg::OFS_TX_EN_SET, mia_pkg::OFS_TX_EN_CLR: rd_nxt[N-1:0] = tx_en_r;
          mia_pkg::OFS_RX_RAW: rd_nxt[N-1:0] = rx_raw_r;
          mia_pkg::OFS_RX_MASKED: rd_nxt[N-1:0] = rx_msk;
          mia_pkg::OFS_RX_EN_SET, mia_pkg::OFS_RX_EN_CLR: rd_nxt[N-1:0] = rx_en_r;
          mia_pkg::OFS_MISC_RAW: rd_nxt[1:0] = {host_raw_r, stats_r};
          mia_pkg::OFS_MISC_MASKED: rd_nxt[1:0] = {host_msk, stats_msk};
          mia_pkg::OFS_MISC_EN_SET, mia_pkg::OFS_MISC_EN_CLR:
            rd_nxt[1:0] = {host_en_r, stats_en_r};
          mia_pkg::OFS_LINK_RAW: rd_nxt[1:0] = link_raw_r;
          mia_pkg::OFS_LINK_MASKED: rd_nxt[1:0] = link_msk;
          mia_pkg::OFS_LINK_EN: rd_nxt[1:0] = link_en_r;
          mia_pkg::OFS_USER_RAW: rd_nxt[1:0] = user_raw_r;
          mia_pkg::OFS_USER_MASKED: rd_nxt[1:0] = user_msk;
          mia_pkg::OFS_USER_EN_SET, mia_pkg::OFS_USER_EN_CLR: rd_nxt[1:0] = user_en_r;
          mia_pkg::OFS_CTRL: rd_nxt[mia_pkg::CTRL_EN_BIT] = irq_en_r;
          default: rd_nxt = mia_pkg::RD_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_r <= mia_pkg::RD_ZERO;
      tx_irq_r <= mia_pkg::RST_CH_EN;
      rx_irq_r <= mia_pkg::RST_CH_EN;
      {stats_irq_r, host_irq_r, link_irq_r, user_irq_r, cpu_irq_r} <= 5'h00;
    end
    else if (!rst_n_r)
    begin
      rdata_r <= mia_pkg::RD_ZERO;
      tx_irq_r <= mia_pkg::RST_CH_EN;
      rx_irq_r <= mia_pkg::RST_CH_EN;
      {stats_irq_r, host_irq_r, link_irq_r, user_irq_r, cpu_irq_r} <= 5'h00;
    end
    else if (clk_en_i)
    begin
      rdata_r <= rd_nxt;
      tx_irq_r <= tx_msk;
      rx_irq_r <= rx_msk;
      stats_irq_r <= stats_msk;
      host_irq_r <= host_msk;
      link_irq_r <= |link_msk;
      user_irq_r <= |user_msk;
      cpu_irq_r <= irq_en_r & any_src;
    end
  end

  assign rdata_o = rdata_r;
  assign tx_done_irq_o = tx_irq_r;
  assign rx_done_irq_o = rx_irq_r;
  assign stats_overflow_irq_o = stats_irq_r;
  assign descriptor_error_irq_o = host_irq_r;
  assign link_change_irq_o = link_irq_r;
  assign user_access_done_irq_o = user_irq_r;
  assign combined_cpu_irq_o = cpu_irq_r;

  // Checks
  chk_cpu_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    clk_en_i && !irq_en_r |=> !combined_cpu_irq_o)
    else $error("combined irq high while disabled");
  chk_cpu_follow: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    clk_en_i && irq_en_r && any_src |=> combined_cpu_irq_o)
    else $error("combined irq missing");
  chk_tx_store: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    clk_en_i && tx_cp_wr_i.valid |=> tx_raw_r[$past(tx_cp_wr_i.ch)])
    else $error("tx store did not raise pending");
  chk_rx_store: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    clk_en_i && rx_cp_wr_i.valid |=> rx_raw_r[$past(rx_cp_wr_i.ch)])
    else $error("rx store did not raise pending");
  chk_tx_ack: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    clk_en_i && wr && cp_sel && !tx_cp_wr_i.valid && wd == tx_cp_r[cp_idx]
    |=> !tx_raw_r[$past(cp_idx)])
    else $error("tx ack did not clear");
  chk_rx_ack: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    clk_en_i && wr && rp_sel && !rx_cp_wr_i.valid && wd == rx_cp_r[cp_idx]
    |=> !rx_raw_r[$past(cp_idx)])
    else $error("rx ack did not clear");
  chk_host_sticky: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    host_raw_r |=> host_raw_r)
    else $error("host error bit cleared");
  chk_host_set: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    clk_en_i && (tx_fault || rx_fault) |=> host_raw_r)
    else $error("descriptor fault not flagged");
  sequence s_reenable;
    clk_en_i && !irq_en_r ##1 clk_en_i && irq_en_r && any_src;
  endsequence
  chk_reedge: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
    s_reenable |=> $rose(combined_cpu_irq_o))
    else $error("no new edge on re-enable");
endmodule

// file: sim/mia_cpu_model.sv
// CPU interrupt controller model: counts rising edges of the combined line
`timescale 1ns/1ps
module mia_cpu_model
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Combined interrupt line
  input wire logic irq_i,
  // Edges the CPU has taken
  output int edges_o
);
  logic irq_d_r;
  // Edge-triggered capture of a level line
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_d_r <= 1'b0;
      edges_o <= 0;
    end
    else
    begin
      irq_d_r <= irq_i;
      if (irq_i === 1'b1 && irq_d_r === 1'b0)
      begin
        edges_o <= edges_o + 1;
      end
    end
  end
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the MAC interrupt aggregator
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic clk_en_i = 1'b1;
  mia_pkg::mia_bus_req_t bus = '0;
  mia_pkg::mia_cp_wr_t tx_cp = '0;
  mia_pkg::mia_cp_wr_t rx_cp = '0;
  mia_pkg::mia_tx_err_t tx_err = '0;
  mia_pkg::mia_rx_err_t rx_err = '0;
  logic [31:0] stats = '0;
  logic [1:0] phy_link = '0;
  logic [1:0] user_go = '0;
  logic [31:0] rdata_o;
  logic [7:0] tx_irq;
  logic [7:0] rx_irq;
  logic stats_irq, desc_irq, link_irq, user_irq, cpu_irq;
  int n_errors = 0;
  int samples_checked = 0;
  int seed = 32'h7e7f;
  int cyc = 0;
  int edges, e0;
  logic [1:0] t;

  always #50 ref_clk_i = ~ref_clk_i;

  mia_top u_dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i),
    .bus_i(bus), .rdata_o(rdata_o), .tx_cp_wr_i(tx_cp), .rx_cp_wr_i(rx_cp),
    .tx_err_i(tx_err), .rx_err_i(rx_err), .stats_msb_i(stats), .phy_link_i(phy_link),
    .user_go_i(user_go), .tx_done_irq_o(tx_irq), .rx_done_irq_o(rx_irq),
    .stats_overflow_irq_o(stats_irq), .descriptor_error_irq_o(desc_irq),
    .link_change_irq_o(link_irq), .user_access_done_irq_o(user_irq),
    .combined_cpu_irq_o(cpu_irq));

  mia_cpu_model u_cpu (.clk_i(ref_clk_i), .rst_n_i(arst_n_i), .irq_i(cpu_irq),
    .edges_o(edges));

  function automatic logic [31:0] masked(input logic [7:0] raw, input logic [7:0] en);
    return {24'h0, raw & en};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge ref_clk_i);
    bus <= {2'b10, ad, d};
    @(posedge ref_clk_i);
    bus <= '0;
  endtask

  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e);
    @(posedge ref_clk_i);
    bus <= {2'b01, ad, 32'h0};
    @(posedge ref_clk_i);
    bus <= '0;
    #1;
    `CHK(rdata_o, e)
  endtask

  task automatic store(input bit rx, input logic [2:0] c, input logic [31:0] ad);
    @(posedge ref_clk_i);
    if (rx) rx_cp <= {1'b1, c, ad};
    else tx_cp <= {1'b1, c, ad};
    @(posedge ref_clk_i);
    rx_cp <= '0;
    tx_cp <= '0;
  endtask

  task automatic do_reset;
    @(posedge ref_clk_i);
    arst_n_i <= 1'b0;
    repeat (16) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    tick(3);
  endtask

  task automatic chan_test(input bit rx);
    logic [7:0] b, en, cp, raw;
    logic [31:0] p [8];
    b = rx ? 8'h10 : 8'h00;
    en = 8'($random(seed));
    raw = 8'hFF;
    wr(b + 8'h08, 32'hFF);
    wr(b + 8'h0C, {24'h0, ~en});
    rd_chk(b + 8'h08, {24'h0, en});
    for (int c = 0; c < 8; c++)
    begin
      p[c] = (c == 0) ? 32'h0 : $random(seed);
      store(rx, 3'(c), p[c]);
    end
    tick(3);
    `CHK(rx ? rx_irq : tx_irq, en)
    rd_chk(b, 32'hFF);
    rd_chk(b + 8'h04, masked(raw, en));
    for (int c = 0; c < 8; c++)
    begin
      cp = (rx ? 8'hA0 : 8'h80) + 8'(4 * c);
      rd_chk(cp, p[c]);
      wr(cp, p[c] ^ 32'h1);
      rd_chk(cp, p[c]);
      rd_chk(b, {24'h0, raw});
      wr(cp, p[c]);
      raw[c] = 1'b0;
      rd_chk(b, {24'h0, raw});
    end
    tick(2);
    `CHK(rx ? rx_irq : tx_irq, 8'h00)
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      report_and_stop;
    end
  end

  initial
  begin
    do_reset;
    `CHK({tx_irq, rx_irq, stats_irq, desc_irq, link_irq, user_irq, cpu_irq}, 21'h0)
    chan_test(1'b0);
    chan_test(1'b1);
    rd_chk(8'h3C, 32'h0);
    wr(8'h3C, 32'hFFFF_FFFF);
    rd_chk(8'h3C, 32'h0);
    // Frozen clock enable ignores a completion store
    @(posedge ref_clk_i);
    clk_en_i <= 1'b0;
    store(1'b0, 3'h1, 32'h5);
    @(posedge ref_clk_i);
    clk_en_i <= 1'b1;
    rd_chk(mia_pkg::OFS_TX_RAW, 32'h0);
    // Statistics level follows the counter top bits, gated by its enable
    @(posedge ref_clk_i);
    stats <= 32'h1 << ($random(seed) & 31);
    tick(4);
    `CHK(stats_irq, 1'b0)
    wr(mia_pkg::OFS_MISC_EN_SET, 32'h1);
    tick(3);
    `CHK(stats_irq, 1'b1)
    rd_chk(mia_pkg::OFS_MISC_RAW, 32'h1);
    rd_chk(mia_pkg::OFS_MISC_MASKED, 32'h1);
    `CHK(cpu_irq, 1'b0)
    wr(mia_pkg::OFS_CTRL, 32'h1);
    tick(3);
    `CHK(cpu_irq, 1'b1)
    rd_chk(mia_pkg::OFS_CTRL, 32'h1);
    e0 = edges;
    wr(mia_pkg::OFS_CTRL, 32'h0);
    tick(3);
    `CHK(cpu_irq, 1'b0)
    wr(mia_pkg::OFS_CTRL, 32'h1);
    tick(3);
    `CHK(edges, e0 + 1)
    @(posedge ref_clk_i);
    stats <= '0;
    tick(4);
    `CHK(stats_irq, 1'b0)
    // Link change on a random nonzero set of the two monitor selects, both enabled
    wr(mia_pkg::OFS_LINK_EN, 32'h3);
    t = 2'($random(seed));
    if (t == 2'h0) t = 2'h3;
    @(posedge ref_clk_i);
    phy_link <= phy_link ^ t;
    tick(6);
    rd_chk(mia_pkg::OFS_LINK_RAW, {30'h0, t});
    `CHK(link_irq, 1'b1)
    wr(mia_pkg::OFS_LINK_MASKED, {30'h0, t});
    tick(3);
    rd_chk(mia_pkg::OFS_LINK_MASKED, 32'h0);
    `CHK(link_irq, 1'b0)
    // Link change with its enable off is not recorded
    wr(mia_pkg::OFS_LINK_EN, 32'h0);
    @(posedge ref_clk_i);
    phy_link <= ~phy_link;
    tick(6);
    rd_chk(mia_pkg::OFS_LINK_RAW, 32'h0);
    `CHK(link_irq, 1'b0)
    // User access completion, only access 0 enabled
    wr(mia_pkg::OFS_USER_EN_SET, 32'h1);
    @(posedge ref_clk_i);
    user_go <= 2'h3;
    tick(6);
    `CHK(user_irq, 1'b0)
    @(posedge ref_clk_i);
    user_go <= 2'h0;
    tick(6);
    rd_chk(mia_pkg::OFS_USER_RAW, 32'h3);
    rd_chk(mia_pkg::OFS_USER_MASKED, 32'h1);
    `CHK(user_irq, 1'b1)
    wr(mia_pkg::OFS_USER_MASKED, 32'h1);
    tick(3);
    rd_chk(mia_pkg::OFS_USER_MASKED, 32'h0);
    `CHK(user_irq, 1'b0)
    // Each descriptor fault alone, sticky until reset
    for (int i = 0; i < 8; i++)
    begin
      do_reset;
      wr(mia_pkg::OFS_MISC_EN_SET, 32'h2);
      @(posedge ref_clk_i);
      {tx_err, rx_err} <= 8'h1 << i;
      @(posedge ref_clk_i);
      {tx_err, rx_err} <= 8'h0;
      tick(3);
      `CHK(desc_irq, 1'b1)
      rd_chk(mia_pkg::OFS_MISC_RAW, 32'h2);
      rd_chk(mia_pkg::OFS_MISC_MASKED, 32'h2);
    end
    wr(mia_pkg::OFS_MISC_EN_CLR, 32'h2);
    tick(3);
    `CHK(desc_irq, 1'b0)
    rd_chk(mia_pkg::OFS_MISC_MASKED, 32'h0);
    rd_chk(mia_pkg::OFS_MISC_RAW, 32'h2);
    do_reset;
    rd_chk(mia_pkg::OFS_MISC_RAW, 32'h0);
    report_and_stop;
  end
endmodule
